// ==== logic/sdram_core_params.svh ====
// constants for the synchronous dram core: geometry, mode fields, command codes
// Notes on behaviour
// - four banks, 4096 rows, 512 columns, 16-bit words
// - active takes bank and row address
// - read/write column sets burst start
// - burst 1,2,4,8 or page; terminate ends early
// - auto precharge closes row after burst
// - new column accepted every clock cycle
// - precharge one bank while accessing another
// - mode register holds until next load
// - mode bit layout: length, order, latency, mode, write
// - read latency two or three clocks
// - write burst field forces single writes
`ifndef SDRAM_CORE_PARAMS_SVH
`define SDRAM_CORE_PARAMS_SVH
`define BANK_COUNT 4
`define ROW_BITS 12
`define COL_BITS 9
`define DATA_BITS 16
`define BL_LO 0
`define BL_HI 2
`define BORDER_BIT 3
`define LAT_LO 4
`define LAT_HI 6
`define WBURST_BIT 9
`define MODE_BITS 12
`define BL_ONE 3'h0
`define BL_TWO 3'h1
`define BL_FOUR 3'h2
`define BL_EIGHT 3'h3
`define BL_PAGE 3'h7
`define LEN_ONE 10'h001
`define LEN_TWO 10'h002
`define LEN_FOUR 10'h004
`define LEN_EIGHT 10'h008
`define LEN_PAGE 10'h200
`define LAT_TWO 3'h2
`define LAT_THREE 3'h3
`define CMD_NOP 4'h7
`define CMD_ACTIVE 4'h3
`define CMD_READ 4'h5
`define CMD_WRITE 4'h4
`define CMD_TERM 4'h6
`define CMD_PRECH 4'h2
`define CMD_REFRESH 4'h1
`define CMD_LOADMODE 4'h0
`define AP_BIT 10
`endif

// ==== logic/sdram_core_pkg.sv ====
// types shared by the synchronous dram core
package sdram_core_pkg;
  typedef enum logic [2:0] {
    burst_idle_s = 3'b001,
    burst_read_s = 3'b010,
    burst_write_s = 3'b100
  } burst_state_t;
endpackage

// ==== logic/sdram_core.sv ====
// synchronous dram die: command decode, bank state, bursts, mode register, storage
`timescale 1ns/1ps
`include "sdram_core_params.svh"
module sdram_core
  import sdram_core_pkg::*;
#(
  parameter int ROWS = 4096,
  parameter int COLS = 512,
  parameter int MEM_ROWS = 4
) (
  input wire logic core_clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic cs_n, // chip select, active low
  input wire logic ras_n, // row strobe, active low
  input wire logic cas_n, // column strobe, active low
  input wire logic we_n, // write enable, active low
  input wire logic [1:0] bank_select_bits, // bank address
  input wire logic [`ROW_BITS-1:0] addr, // row, column or mode value
  input wire logic [`DATA_BITS-1:0] dq_in, // write data
  input wire logic rd_ready, // receiver can accept read data
  output logic [`DATA_BITS-1:0] dq_out, // read data
  output logic dq_valid, // read data valid
  output logic dq_oe_n, // data output enable, low while driving
  output logic [`BANK_COUNT-1:0] bank_open, // bank has an open row
  output logic [`MODE_BITS-1:0] mode_out // stored mode register
);
  localparam int ABITS = $clog2(MEM_ROWS) + `COL_BITS;
  // storage folded: only low row bits kept so simulation memory stays small
  logic [`DATA_BITS-1:0] mem [`BANK_COUNT][MEM_ROWS*COLS];
  logic [`ROW_BITS-1:0] open_row_ff [`BANK_COUNT];
  logic [`BANK_COUNT-1:0] open_ff;
  logic [`MODE_BITS-1:0] operating_mode_register_ff;
  burst_state_t state_ff;
  logic [1:0] bank_ff;
  logic [`COL_BITS-1:0] start_col_ff;
  logic [`COL_BITS-1:0] cnt_ff;
  logic [`COL_BITS:0] len_ff;
  logic ap_ff;
  // refresh decodes to nothing: this storage never decays
  logic [3:0] cmd;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  wire is_act = cmd == `CMD_ACTIVE;
  wire is_rd = cmd == `CMD_READ;
  wire is_wr = cmd == `CMD_WRITE;
  wire is_term = cmd == `CMD_TERM;
  wire is_pre = cmd == `CMD_PRECH;
  wire is_lmr = cmd == `CMD_LOADMODE;
  wire [2:0] bl = operating_mode_register_ff[`BL_HI:`BL_LO];
  wire interleave = operating_mode_register_ff[`BORDER_BIT];
  wire [2:0] lat = operating_mode_register_ff[`LAT_HI:`LAT_LO];
  wire single_wr = operating_mode_register_ff[`WBURST_BIT];
  // length in words for the programmed field; reserved codes act as one
  // so a stray setting cannot run a burst off into the next block
  wire len_two = bl == `BL_TWO;
  wire len_four = bl == `BL_FOUR;
  wire len_eight = bl == `BL_EIGHT;
  wire len_page = bl == `BL_PAGE;
  wire [`COL_BITS:0] prog_len =
    len_two ? `LEN_TWO :
    len_four ? `LEN_FOUR :
    len_eight ? `LEN_EIGHT :
    len_page ? `LEN_PAGE : `LEN_ONE;
  wire [`COL_BITS:0] new_len = (is_wr && single_wr) ? `LEN_ONE : prog_len;
  wire [`COL_BITS-1:0] mask_ff = len_ff[`COL_BITS-1:0] - 9'h001;
  // column order within the block; page bursts are sequential only
  wire use_inter = interleave && (len_ff != `LEN_PAGE) && (len_ff != `LEN_ONE);
  wire [`COL_BITS-1:0] low_seq = (start_col_ff + cnt_ff) & mask_ff;
  wire [`COL_BITS-1:0] low_int = (start_col_ff ^ cnt_ff) & mask_ff;
  wire [`COL_BITS-1:0] cur_col = (start_col_ff & ~mask_ff) |
    (use_inter ? low_int : low_seq);
  wire last_beat = ({1'b0, cnt_ff} + 10'h001) >= len_ff;
  wire in_burst = state_ff != burst_idle_s;
  // new read or write interrupts the running one, so a column can change each cycle
  wire start_acc = (is_rd || is_wr) && open_ff[bank_select_bits];
  wire burst_done = in_burst && last_beat && !start_acc && !is_term;
  wire [ABITS-1:0] cur_addr =
    {open_row_ff[bank_ff][$clog2(MEM_ROWS)-1:0], cur_col};
  wire wr_beat = state_ff == burst_write_s;
  wire rd_beat = state_ff == burst_read_s;
  burst_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    if (start_acc) begin
      nxt_state = is_rd ? burst_read_s : burst_write_s;
    end else if (is_term || (in_burst && last_beat)) begin
      nxt_state = burst_idle_s;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= burst_idle_s;
      cnt_ff <= 9'h000;
      len_ff <= 10'h001;
      start_col_ff <= 9'h000;
      bank_ff <= 2'h0;
      ap_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start_acc) begin
        bank_ff <= bank_select_bits;
        start_col_ff <= addr[`COL_BITS-1:0];
        len_ff <= new_len;
        cnt_ff <= 9'h000;
        ap_ff <= addr[`AP_BIT];
      end else if (in_burst) begin
        cnt_ff <= cnt_ff + 9'h001;
      end
    end
  end
  // per-bank open state; precharge of one bank is independent of another's burst
  // a precharge to an idle bank is harmless, so precharge-all needs no check
  genvar b;
  generate
    for (b = 0; b < `BANK_COUNT; b++) begin : g_bank
      wire sel = bank_select_bits == b;
      wire pre_hit = is_pre && (addr[`AP_BIT] || sel);
      wire auto_pre = burst_done && ap_ff && (bank_ff == b);
      always_ff @(posedge core_clk) begin
        if (rst) begin
          open_ff[b] <= 1'b0;
          open_row_ff[b] <= 12'h000;
        end else if (is_act && sel) begin
          open_ff[b] <= 1'b1;
          open_row_ff[b] <= addr;
        end else if (pre_hit || auto_pre) begin
          open_ff[b] <= 1'b0;
        end
      end
    end
  endgenerate
  // mode only changes on a load or on reset, which clears it; no reset value exists on the real die
  always_ff @(posedge core_clk) begin
    if (rst) begin
      operating_mode_register_ff <= 12'h000;
    end else if (is_lmr) begin
      operating_mode_register_ff <= addr;
    end
  end
  // write beats land one edge after their command; a new access on that edge wins
  always_ff @(posedge core_clk) begin
    if (wr_beat && !start_acc) begin
      mem[bank_ff][cur_addr] <= dq_in;
    end
  end
  // read latency pipe: first word reaches the buffer latency edges after the read
  localparam int PIPE = 2;
  logic [`DATA_BITS-1:0] pipe_d_ff [PIPE];
  logic [PIPE-1:0] pipe_v_ff;
  wire [`DATA_BITS-1:0] rd_word = mem[bank_ff][cur_addr];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pipe_v_ff <= 2'h0;
    end else begin
      pipe_v_ff <= {pipe_v_ff[0], rd_beat};
    end
  end
  // data stages carry no reset; the valid bits alone qualify them
  genvar p;
  generate
    for (p = 0; p < PIPE; p++) begin : g_pipe
      wire [`DATA_BITS-1:0] stage_in;
      if (p == 0) begin : g_first
        assign stage_in = rd_word;
      end else begin : g_next
        assign stage_in = pipe_d_ff[p-1];
      end
      always_ff @(posedge core_clk) begin
        pipe_d_ff[p] <= stage_in;
      end
    end
  endgenerate
  // latency codes other than three fall back to two
  wire tap_v = (lat == `LAT_THREE) ? pipe_v_ff[1] : pipe_v_ff[0];
  wire [`DATA_BITS-1:0] tap_d = (lat == `LAT_THREE) ? pipe_d_ff[1] : pipe_d_ff[0];
  // two-entry skid buffer; a stalled receiver loses words only once both entries are full
  logic [`DATA_BITS-1:0] buf_ff [2];
  logic [1:0] cnt_buf_ff;
  logic wp_ff;
  logic rp_ff;
  // output stage reloads when it is empty or the receiver takes its word
  wire out_free = !dq_valid || rd_ready;
  wire pop = out_free && (cnt_buf_ff != 2'h0);
  // the read pipe cannot wait, so a push into a full buffer needs a pop
  wire push = tap_v && ((cnt_buf_ff != 2'h2) || pop);
  wire [1:0] nxt_cnt_buf = cnt_buf_ff + {1'b0, push} - {1'b0, pop};
  wire nxt_dq_valid = pop || !out_free;
  wire [`DATA_BITS-1:0] nxt_dq_out = pop ? buf_ff[rp_ff] : dq_out;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_buf_ff <= 2'h0;
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
    end else begin
      cnt_buf_ff <= nxt_cnt_buf;
      if (push) begin
        wp_ff <= ~wp_ff;
      end
      if (pop) begin
        rp_ff <= ~rp_ff;
      end
    end
    if (push) begin
      buf_ff[wp_ff] <= tap_d;
    end
  end
  // every output is a flip-flop; enable tracks valid so the pins never float mid-word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dq_out <= 16'h0000;
      dq_valid <= 1'b0;
      dq_oe_n <= 1'b1;
      bank_open <= 4'h0;
      mode_out <= 12'h000;
    end else begin
      dq_out <= nxt_dq_out;
      dq_valid <= nxt_dq_valid;
      dq_oe_n <= !nxt_dq_valid;
      bank_open <= open_ff;
      mode_out <= operating_mode_register_ff;
    end
  end
endmodule

// ==== sim/sdram_core_monitor.sv ====
// port checker for the dram core
`timescale 1ns/1ps
module sdram_core_monitor (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic cs_n, // select
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write enable
  input wire logic [1:0] bank_select_bits, // bank
  input wire logic [11:0] addr, // address
  input wire logic rd_ready, // receiver ready
  input wire logic [15:0] dq_out, // read data
  input wire logic dq_valid, // data valid
  input wire logic dq_oe_n, // output enable
  input wire logic [3:0] bank_open, // open banks
  input wire logic [11:0] mode_out // mode copy
);
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire ld = cmd == 4'h0;
  wire hit = bank_open[bank_select_bits];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence quiet_s; !ld [*3]; endsequence
  sequence load_s; ld ##1 !ld; endsequence
  reset_state_a: assert property ($fell(rst) |-> !dq_valid && dq_oe_n && bank_open == 4'h0)
    else $error("outputs not cleared");
  oe_follows_a: assert property (dq_oe_n == !dq_valid)
    else $error("enable not tied to valid");
  active_opens_a: assert property (
    cmd == 4'h3 |=> ##1 bank_open[$past(bank_select_bits, 2)])
    else $error("bank not opened");
  prech_closes_a: assert property (
    cmd == 4'h2 |=> ##1 ($past(addr[10], 2) ? bank_open == 4'h0 :
    !bank_open[$past(bank_select_bits, 2)]))
    else $error("bank not closed");
  mode_load_a: assert property (load_s |-> ##1 mode_out == $past(addr, 2))
    else $error("mode value not stored");
  mode_hold_a: assert property (quiet_s |=> $stable(mode_out))
    else $error("mode changed without load");
  stall_hold_a: assert property (dq_valid && !rd_ready |=> dq_valid && $stable(dq_out))
    else $error("data lost during stall");
  read_latency_a: assert property (cmd == 4'h5 && hit |-> ##[2:6] dq_valid)
    else $error("read data late");
endmodule

// ==== sim/sdram_ctl_model.sv ====
// controller model driving the command pins
`timescale 1ns/1ps
module sdram_ctl_model #(
  parameter int WAIT_CYC = 5000
) (
  input wire logic core_clk, // clock
  output logic [3:0] cmd_pins, // select, row, column, write levels
  output logic [1:0] bank, // bank
  output logic [11:0] addr, // address
  output logic [15:0] wdata // write data
);
  initial begin
    {cmd_pins, bank, addr, wdata} = {4'h7, 2'h0, 12'h000, 16'h0000};
  end
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic [15:0] d);
    @(negedge core_clk);
    {cmd_pins, bank, addr, wdata} = {c, b, a, d};
  endtask
  task automatic init_seq(input logic [11:0] mode);
    repeat (WAIT_CYC) issue(4'h7, 2'h0, ~addr, ~wdata);
    issue(4'h2, 2'h0, 12'h400, 16'h0000);
    repeat (2) issue(4'h1, 2'h0, 12'h000, 16'h0000);
    issue(4'h0, 2'h0, mode, 16'h0000);
    repeat (3) issue(4'h7, 2'h0, 12'hFFF, 16'h0000);
  endtask
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the dram core
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic rd_ready = 1'b1;
  logic [3:0] cmd;
  logic [1:0] bank;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic [15:0] dq_out;
  logic dq_valid;
  logic dq_oe_n;
  logic [3:0] bank_open;
  logic [11:0] mode_out;
  logic [15:0] mem [0:7];
  int fails = 0;
  int checks_done = 0;
  logic [1:0] b;
  sdram_ctl_model ctl (.core_clk(core_clk), .cmd_pins(cmd), .bank(bank), .addr(addr),
    .wdata(wdata));
  sdram_core uut (.core_clk(core_clk), .rst(rst), .cs_n(cmd[3]), .ras_n(cmd[2]),
    .cas_n(cmd[1]), .we_n(cmd[0]), .bank_select_bits(bank), .addr(addr), .dq_in(wdata),
    .rd_ready(rd_ready), .dq_out(dq_out), .dq_valid(dq_valid), .dq_oe_n(dq_oe_n),
    .bank_open(bank_open), .mode_out(mode_out));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // order inside the aligned block; interleave flips the low column bits
  function automatic logic [15:0] exp_word(input logic [8:0] c, input int i, input int n,
                                           input bit inter);
    logic [8:0] k;
    k = inter ? (c ^ 9'(i)) : (c + 9'(i));
    return mem[3'(k & 9'(n - 1))];
  endfunction
  task automatic collect(input logic [8:0] c, input int n, input bit inter);
    int got = 0;
    int st = 0;
    logic [15:0] last = 16'h0000;
    for (int i = 0; i < 40 && got < n; i++) begin
      @(negedge core_clk);
      if (st == 1) check(dq_out, last);
      if (dq_valid === 1'b1 && st == 0) begin
        last = dq_out;
        rd_ready = 1'b0;
        st = 1;
      end else begin
        rd_ready = 1'b1;
        st = (st == 1) ? 2 : st;
        if (dq_valid === 1'b1) begin
          check(dq_out, exp_word(c, got, n, inter));
          check(16'(dq_oe_n), 16'h0000);
          got++;
        end
      end
    end
    check(16'(got), 16'(n));
  endtask
  initial begin
    void'($urandom(22));
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    // burst four, latency three, single-location writes
    ctl.init_seq(12'h232);
    check(16'(mode_out), 16'h0232);
    b = 2'($urandom());
    ctl.issue(4'h3, b, 12'($urandom()), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      mem[i] = 16'($urandom());
      ctl.issue(4'h4, b, 12'(4 + i), 16'h0000);
      ctl.issue(4'h7, b, 12'h000, mem[i]);
    end
    // a wrongly bursting write would spill these into the block
    repeat (2) ctl.issue(4'h7, b, 12'h000, ~mem[3]);
    check(16'(bank_open), 16'(4'h1 << b));
    ctl.issue(4'h5, b, 12'h405, 16'h0000);
    ctl.issue(4'h7, b, 12'h000, 16'h0000);
    collect(9'h005, 4, 1'h0);
    repeat (4) @(negedge core_clk);
    check(16'(bank_open), 16'h0000);
    ctl.issue(4'h5, b, 12'h005, 16'h0000);
    ctl.issue(4'h7, b, 12'h000, 16'h0000);
    repeat (10) @(negedge core_clk);
    check(16'(dq_valid), 16'h0000);
    check(16'(mode_out), 16'h0232);
    // burst eight, interleaved, latency two, burst writes
    ctl.issue(4'h0, 2'h0, 12'h02B, 16'h0000);
    repeat (2) ctl.issue(4'h7, 2'h0, 12'h000, 16'h0000);
    ctl.issue(4'h3, b ^ 2'h1, 12'($urandom()), 16'h0000);
    ctl.issue(4'h3, b, 12'($urandom()), 16'h0000);
    ctl.issue(4'h4, b ^ 2'h1, 12'h008, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      mem[i] = 16'($urandom());
      ctl.issue(4'h7, b ^ 2'h1, 12'h000, mem[i]);
    end
    ctl.issue(4'h5, b ^ 2'h1, 12'h00B, 16'h0000);
    ctl.issue(4'h2, b, 12'h000, 16'h0000);
    ctl.issue(4'h7, b, 12'h000, 16'h0000);
    collect(9'h00B, 8, 1'h1);
    check(16'(bank_open), 16'(4'h1 << (b ^ 2'h1)));
    check(16'(mode_out), 16'h002B);
    // terminate cuts the burst after its first word
    ctl.issue(4'h5, b ^ 2'h1, 12'h008, 16'h0000);
    ctl.issue(4'h6, b ^ 2'h1, 12'h000, 16'h0000);
    ctl.issue(4'h7, b ^ 2'h1, 12'h000, 16'h0000);
    collect(9'h008, 1, 1'h0);
    @(negedge core_clk);
    check(16'(dq_valid), 16'h0000);
    stop_test();
  end
endmodule
bind sdram_core sdram_core_monitor mon (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_bits(bank_select_bits),
  .addr(addr), .rd_ready(rd_ready), .dq_out(dq_out), .dq_valid(dq_valid),
  .dq_oe_n(dq_oe_n), .bank_open(bank_open), .mode_out(mode_out));
